// file: oscsel_map.svh
// oscsel_map.svh: register offsets, field positions, reset values and timing counts
// assumes: included by the oscillator source select module and the testbench
`ifndef OSCSEL_MAP_SVH
`define OSCSEL_MAP_SVH
`define OSCSEL_ADDR_W        2
`define OSCSEL_OFS_STATUS    2'h0
`define OSCSEL_OFS_TRIM      2'h1
`define OSCSEL_OFS_CTRL      2'h2
`define OSCSEL_BIT_REQUEST   1
`define OSCSEL_BIT_ENGAGED   0
`define OSCSEL_BIT_CLKOUT_EN 0
`define OSCSEL_TRIM_RESET    8'h80
`define OSCSEL_EXT_EDGES     2'h2
`define OSCSEL_INT_FREQ_KHZ  12800
`define OSCSEL_BUS_FREQ_KHZ  3200
`endif

// file: oscsel_pkg.sv
// oscsel_pkg.sv: types for the oscillator source select block
// assumes: oscsel_map.svh supplies the numeric constants
package oscsel_pkg;
  typedef enum logic [1:0] {
    OSCSEL_SRC_INT,
    OSCSEL_SRC_EXT,
    OSCSEL_SRC_RC,
    OSCSEL_SRC_XTAL
  } oscsel_src_e;
  typedef enum logic [1:0] {
    OSCSEL_SW_INTERNAL,
    OSCSEL_SW_WAIT_EDGES,
    OSCSEL_SW_ENGAGED
  } oscsel_sw_e;
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } oscsel_bus_s;
  typedef struct packed {
    logic o;
    logic oe_n;
  } oscsel_pin_s;
endpackage

// file: oscsel_top.sv
// oscsel_top.sv: oscillator source selection, clock output pin control, switch-over
// assumes: analogue oscillators outside; source clocks arrive as sampled levels
`timescale 1ns/1ns
`include "oscsel_map.svh"
module oscsel_top (
  input  wire logic                clk_sys,
  input  wire logic                rst_n,
  input  wire logic                clk_en,
  input  wire oscsel_pkg::oscsel_bus_s bus,
  output logic [7:0]               rdata,
  input  wire logic [1:0]          source_select,
  input  wire logic                osc_enable_from_sysunit,
  input  wire logic                stop_mode,
  input  wire logic                wait_mode,
  input  wire logic                break_state,
  input  wire logic                monitor_bypass,
  input  wire logic                test_mode_one,
  input  wire logic                test_mode_two,
  input  wire logic                clock_in_pin,
  input  wire logic                crystal_clock,
  input  wire logic                resistor_cap_clock,
  input  wire logic                internal_osc_clock,
  input  wire logic                port_a_bit4_out,
  input  wire logic                port_a_bit4_oe_n,
  output logic                     clock_out_pin_o,
  output logic                     clock_out_pin_oe_n,
  output logic                     clock_in_pin_shared,
  output logic                     port_bit4_owned,
  output logic                     full_rate_clock,
  output logic                     half_rate_clock,
  output logic                     internal_osc_enable,
  output logic                     ext_gen_enable,
  output logic [7:0]               trim_factor
);
  // source clocks come from outside this clock: three-stage sampling
  logic [2:0] ext_sync_r;
  logic [2:0] xtal_sync_r;
  logic [2:0] rc_sync_r;
  logic [2:0] int_sync_r;
  logic       ext_lvl_r;
  logic       xtal_lvl_r;
  logic       rc_lvl_r;
  logic       int_lvl_r;
  logic       request_r;
  logic       request_nxt;
  logic       clkout_en_r;
  logic [7:0] trim_r;
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [1:0] edge_cnt_r;
  logic       full_r;
  logic       half_r;
  logic       full_prev_r;
  oscsel_pkg::oscsel_sw_e sw_r;
  oscsel_pkg::oscsel_sw_e sw_nxt;
  oscsel_pkg::oscsel_src_e src;
  oscsel_pkg::oscsel_pin_s pin;

  function automatic logic sel_is(input logic [1:0] sel, input oscsel_pkg::oscsel_src_e s);
    sel_is = (sel == s);
  endfunction

  // a level counts once the second and third stages agree
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      ext_sync_r  <= 3'h0;
      xtal_sync_r <= 3'h0;
      rc_sync_r   <= 3'h0;
      int_sync_r  <= 3'h0;
      ext_lvl_r   <= 1'b0;
      xtal_lvl_r  <= 1'b0;
      rc_lvl_r    <= 1'b0;
      int_lvl_r   <= 1'b0;
    end else if (clk_en) begin
      ext_sync_r  <= {ext_sync_r[1:0], clock_in_pin};
      xtal_sync_r <= {xtal_sync_r[1:0], crystal_clock};
      rc_sync_r   <= {rc_sync_r[1:0], resistor_cap_clock};
      int_sync_r  <= {int_sync_r[1:0], internal_osc_clock};
      if (ext_sync_r[1] == ext_sync_r[2])
        ext_lvl_r <= ext_sync_r[2];
      if (xtal_sync_r[1] == xtal_sync_r[2])
        xtal_lvl_r <= xtal_sync_r[2];
      if (rc_sync_r[1] == rc_sync_r[2])
        rc_lvl_r <= rc_sync_r[2];
      if (int_sync_r[1] == int_sync_r[2])
        int_lvl_r <= int_sync_r[2];
    end
  end

  assign src = oscsel_pkg::oscsel_src_e'(source_select);

  // request bit is still stored and read back, but ignored for switch-over in monitor bypass and test modes
  wire req_blocked = monitor_bypass | test_mode_one | test_mode_two;
  wire src_external = !sel_is(source_select, oscsel_pkg::OSCSEL_SRC_INT);
  wire engaged = (sw_r == oscsel_pkg::OSCSEL_SW_ENGAGED);
  wire req_eff = request_r & !req_blocked & src_external;

  wire ext_src_lvl;
  assign ext_src_lvl = sel_is(source_select, oscsel_pkg::OSCSEL_SRC_EXT)  ? ext_lvl_r  :
                       sel_is(source_select, oscsel_pkg::OSCSEL_SRC_XTAL) ? xtal_lvl_r :
                       rc_lvl_r;
  wire ext_rise = ext_src_lvl & !full_prev_r;

  // until engaged the internal oscillator drives the clock path
  wire sel_lvl = engaged ? ext_src_lvl : int_lvl_r;
  // stop halts the full-rate clock and the internal oscillator, not the external generator enable; wait and break do not touch them
  wire run = osc_enable_from_sysunit & !stop_mode;

  // register decode
  wire wr_status = bus.wr & (bus.addr == `OSCSEL_OFS_STATUS);
  wire wr_trim   = bus.wr & (bus.addr == `OSCSEL_OFS_TRIM);
  wire wr_ctrl   = bus.wr & (bus.addr == `OSCSEL_OFS_CTRL);
  wire [7:0] status_view = {6'h00, request_r, engaged};

  always_comb begin
    request_nxt = request_r;
    if (wr_status)
      request_nxt = bus.wdata[`OSCSEL_BIT_REQUEST];
  end

  always_comb begin
    unique case (bus.addr)
      `OSCSEL_OFS_STATUS: rdata_nxt = status_view;
      `OSCSEL_OFS_TRIM:   rdata_nxt = trim_r;
      `OSCSEL_OFS_CTRL:   rdata_nxt = {7'h00, clkout_en_r};
      default:            rdata_nxt = 8'h00;
    endcase
    if (!bus.rd)
      rdata_nxt = 8'h00;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      request_r   <= 1'b0;
      trim_r      <= `OSCSEL_TRIM_RESET;
      clkout_en_r <= 1'b0;
      rdata_r     <= 8'h00;
    end else if (clk_en) begin
      request_r <= request_nxt;
      rdata_r   <= rdata_nxt;
      if (wr_trim)
        trim_r <= bus.wdata;
      if (wr_ctrl)
        clkout_en_r <= bus.wdata[`OSCSEL_BIT_CLKOUT_EN];
    end
  end

  // switch-over: count two rising edges of the external source, then engage
  always_comb begin
    sw_nxt = sw_r;
    unique case (sw_r)
      oscsel_pkg::OSCSEL_SW_INTERNAL:
        if (req_eff)
          sw_nxt = oscsel_pkg::OSCSEL_SW_WAIT_EDGES;
      oscsel_pkg::OSCSEL_SW_WAIT_EDGES:
        if (!req_eff)
          sw_nxt = oscsel_pkg::OSCSEL_SW_INTERNAL;
        else if (ext_rise && edge_cnt_r == `OSCSEL_EXT_EDGES - 2'h1)
          sw_nxt = oscsel_pkg::OSCSEL_SW_ENGAGED;
      oscsel_pkg::OSCSEL_SW_ENGAGED:
        sw_nxt = oscsel_pkg::OSCSEL_SW_ENGAGED;
      default:
        sw_nxt = oscsel_pkg::OSCSEL_SW_INTERNAL;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      sw_r        <= oscsel_pkg::OSCSEL_SW_INTERNAL;
      edge_cnt_r  <= 2'h0;
      full_prev_r <= 1'b0;
    end else if (clk_en) begin
      sw_r        <= sw_nxt;
      full_prev_r <= ext_src_lvl;
      if (sw_r != oscsel_pkg::OSCSEL_SW_WAIT_EDGES)
        edge_cnt_r <= 2'h0;
      else if (ext_rise)
        edge_cnt_r <= edge_cnt_r + 2'h1;
    end
  end

  // clocks: full follows source, half toggles on full rising edge
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      full_r <= 1'b0;
      half_r <= 1'b0;
    end else if (clk_en) begin
      if (run) begin
        full_r <= sel_lvl;
        if (sel_lvl && !full_r)
          half_r <= !half_r;
      end else begin
        full_r <= 1'b0;
      end
    end
  end

  // clock output pin function
  always_comb begin
    pin.o    = port_a_bit4_out;
    pin.oe_n = port_a_bit4_oe_n;
    port_bit4_owned = 1'b1;
    unique case (src)
      oscsel_pkg::OSCSEL_SRC_EXT: begin
        pin.o    = port_a_bit4_out;
        pin.oe_n = port_a_bit4_oe_n;
      end
      oscsel_pkg::OSCSEL_SRC_XTAL: begin
        pin.o    = !xtal_lvl_r;
        pin.oe_n = 1'b0;
        port_bit4_owned = 1'b0;
      end
      default: begin
        if (clkout_en_r) begin
          pin.o    = full_r;
          pin.oe_n = 1'b0;
          port_bit4_owned = 1'b0;
        end
      end
    endcase
  end

  assign clock_out_pin_o     = pin.o;
  assign clock_out_pin_oe_n  = pin.oe_n;
  assign clock_in_pin_shared = (src == oscsel_pkg::OSCSEL_SRC_INT);
  assign full_rate_clock     = full_r;
  assign half_rate_clock     = half_r;
  assign internal_osc_enable = run & !engaged;
  assign ext_gen_enable      = req_eff | engaged;
  assign trim_factor         = trim_r;
  assign rdata               = rdata_r;

  // checks
  chk_stop_halts_full: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && stop_mode |=> !full_rate_clock)
    else $error("full-rate clock ran during stop");
  chk_trim_reset: assert property (@(posedge clk_sys)
    !rst_n |=> trim_factor == `OSCSEL_TRIM_RESET)
    else $error("trim not at reset value");
  chk_request_reset: assert property (@(posedge clk_sys)
    !rst_n |=> rdata == 8'h00 && !ext_gen_enable)
    else $error("request not cleared by reset");
  chk_engaged_sticky: assert property (@(posedge clk_sys) disable iff (!rst_n)
    engaged |=> engaged)
    else $error("engaged dropped without reset");
  chk_blocked_no_switch: assert property (@(posedge clk_sys) disable iff (!rst_n)
    req_blocked && !engaged |=> !engaged)
    else $error("switch while request ignored");
  chk_ext_pin_port: assert property (@(posedge clk_sys) disable iff (!rst_n)
    src == oscsel_pkg::OSCSEL_SRC_EXT |-> clock_out_pin_oe_n == port_a_bit4_oe_n)
    else $error("clock out pin not port bit in ext mode");
  chk_xtal_pin_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    src == oscsel_pkg::OSCSEL_SRC_XTAL |-> !clock_out_pin_oe_n && !port_bit4_owned)
    else $error("crystal pin not driven");
  chk_half_toggles: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && run && sel_lvl && !full_r |=> half_rate_clock != $past(half_rate_clock))
    else $error("half-rate clock missed toggle");
  chk_trim_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && wr_trim |=> trim_factor == $past(bus.wdata))
    else $error("trim write lost");
  chk_engage_cause: assert property (@(posedge clk_sys) disable iff (!rst_n)
    !engaged ##1 engaged |-> $past(req_eff) && $past(ext_rise))
    else $error("engaged without edge");

  // wait and break must leave the clock path untouched
  chk_wait_keeps_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && wait_mode && run |=> full_rate_clock == $past(sel_lvl))
    else $error("full-rate clock disturbed in wait");

  chk_break_keeps_clock: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && break_state && run |=> full_rate_clock == $past(sel_lvl))
    else $error("full-rate clock disturbed in break");

  chk_enable_gates_osc: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && !osc_enable_from_sysunit |=> !full_rate_clock)
    else $error("full-rate clock ran without oscillator enable");

  chk_full_follows_src: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && run |=> full_rate_clock == $past(sel_lvl))
    else $error("full-rate clock not following source");

  // status readback carries the live engaged state
  chk_engaged_readback: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && bus.rd && bus.addr == `OSCSEL_OFS_STATUS |=>
      rdata[`OSCSEL_BIT_ENGAGED] == $past(engaged))
    else $error("engaged bit readback wrong");

  chk_request_write: assert property (@(posedge clk_sys) disable iff (!rst_n)
    clk_en && wr_status |=> request_r == $past(bus.wdata[`OSCSEL_BIT_REQUEST]))
    else $error("request bit write lost");

  // internal and RC sources hand the pin to the clock only when enabled
  chk_clkout_drive: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (src == oscsel_pkg::OSCSEL_SRC_INT || src == oscsel_pkg::OSCSEL_SRC_RC) && clkout_en_r
      |-> !clock_out_pin_oe_n && clock_out_pin_o == full_rate_clock)
    else $error("clock out pin not driving full-rate clock");

  chk_clkout_port: assert property (@(posedge clk_sys) disable iff (!rst_n)
    (src == oscsel_pkg::OSCSEL_SRC_INT || src == oscsel_pkg::OSCSEL_SRC_RC) && !clkout_en_r
      |-> port_bit4_owned && clock_out_pin_oe_n == port_a_bit4_oe_n)
    else $error("clock out pin not released to port bit");

  chk_int_off_engaged: assert property (@(posedge clk_sys) disable iff (!rst_n)
    engaged |-> !internal_osc_enable)
    else $error("internal oscillator left running after engage");

  // one external edge alone must never engage
  chk_two_edges: assert property (@(posedge clk_sys) disable iff (!rst_n)
    sw_r == oscsel_pkg::OSCSEL_SW_WAIT_EDGES && edge_cnt_r == 2'h0 |=> !engaged)
    else $error("engaged before second edge");

  chk_reset_internal: assert property (@(posedge clk_sys)
    !rst_n |=> sw_r == oscsel_pkg::OSCSEL_SW_INTERNAL)
    else $error("reset left external path selected");

  cov_engage: cover property (@(posedge clk_sys) disable iff (!rst_n) !engaged ##1 engaged);
  cov_stop: cover property (@(posedge clk_sys) disable iff (!rst_n) stop_mode ##1 !stop_mode);
  cov_clkout: cover property (@(posedge clk_sys) disable iff (!rst_n)
    clkout_en_r && src == oscsel_pkg::OSCSEL_SRC_RC);
  cov_blocked_req: cover property (@(posedge clk_sys) disable iff (!rst_n)
    req_blocked && request_r);
endmodule // oscsel_top

// file: oscsel_src_model.sv
// oscsel_src_model.sv: behavioural far-side clock sources for the oscillator select block
// assumes: sources are slow levels against clk_sys, each at its own rate except RC and crystal, which share one
`timescale 1ns/1ns
module oscsel_src_model (
  input  wire logic clk_sys,
  input  wire logic rst_n,
  input  wire logic run_int,
  input  wire logic run_ext,
  output logic      internal_osc_clock,
  output logic      clock_in_pin,
  output logic      resistor_cap_clock,
  output logic      crystal_clock
);
  logic [7:0] cnt_r;
  always_ff @(posedge clk_sys) begin
    cnt_r <= rst_n ? cnt_r + 8'h01 : 8'h00;
  end
  // a disabled oscillator stands low
  assign internal_osc_clock = run_int & cnt_r[1];
  assign clock_in_pin       = run_ext & cnt_r[2];
  assign resistor_cap_clock = cnt_r[3];
  assign crystal_clock      = cnt_r[3] ^ cnt_r[2];
endmodule // oscsel_src_model

// file: testbench.sv
// testbench.sv: self-checking bench for the oscillator source select block
// assumes: register port with read data one cycle after the read strobe
`timescale 1ns/1ns
`include "oscsel_map.svh"
module testbench;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic [1:0] src = 2'h0;
  logic osc_en = 1'b1, stop_m = 1'b0, wait_m = 1'b0, brk = 1'b0;
  logic [2:0] blk = 3'h0;
  logic run_ext = 1'b1;
  logic en = 1'b1;
  logic eng_exp = 1'b0;
  oscsel_pkg::oscsel_bus_s bus = '0;
  logic [7:0] rdata, trim_factor, rd;
  logic pin_o, pin_oe_n, in_shared, owned, full, half, int_en, ext_en;
  logic c_int, c_pin, c_rc, c_xt, src_clk, f_d, h_d, s_d;
  int miscompares = 0, checks_done = 0, n_full, n_half, n_src;
  always #10 clk_sys = ~clk_sys;
  oscsel_src_model SRC (.clk_sys(clk_sys), .rst_n(rst_n), .run_int(int_en),
    .run_ext(run_ext), .internal_osc_clock(c_int), .clock_in_pin(c_pin),
    .resistor_cap_clock(c_rc), .crystal_clock(c_xt));
  oscsel_top DUT (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(en), .bus(bus), .rdata(rdata),
    .source_select(src), .osc_enable_from_sysunit(osc_en), .stop_mode(stop_m),
    .wait_mode(wait_m), .break_state(brk), .monitor_bypass(blk[0]),
    .test_mode_one(blk[1]), .test_mode_two(blk[2]), .clock_in_pin(c_pin),
    .crystal_clock(c_xt), .resistor_cap_clock(c_rc), .internal_osc_clock(c_int),
    .port_a_bit4_out(1'b1), .port_a_bit4_oe_n(1'b1), .clock_out_pin_o(pin_o),
    .clock_out_pin_oe_n(pin_oe_n), .clock_in_pin_shared(in_shared),
    .port_bit4_owned(owned), .full_rate_clock(full), .half_rate_clock(half),
    .internal_osc_enable(int_en), .ext_gen_enable(ext_en), .trim_factor(trim_factor));
  // the internal source drives the clock path until the switch-over engages
  assign src_clk = !eng_exp ? c_int : src == 2'h1 ? c_pin : src == 2'h2 ? c_rc : c_xt;
  always @(posedge clk_sys) begin
    f_d <= full;
    h_d <= half;
    s_d <= src_clk;
    if (full && !f_d) n_full++;
    if (half !== h_d) n_half++;
    if (src_clk && !s_d) n_src++;
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks_done++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk_sys) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys) bus <= '0;
  endtask
  task automatic rdr(input logic [1:0] a);
    @(posedge clk_sys) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys) bus <= '0;
    #1 rd = rdata;
  endtask
  task automatic do_reset();
    @(posedge clk_sys) rst_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
  endtask
  task automatic win(input int n);
    @(posedge clk_sys);
    n_full = 0; n_half = 0; n_src = 0;
    repeat (n) @(posedge clk_sys);
  endtask
  function automatic logic [7:0] near(input int a, input int b);
    return {7'h0, (a - b <= 1) && (b - a <= 1)};
  endfunction
  task automatic test_done();
    $display("checks %0d miscompares %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    test_done();
  end
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    rdr(2'h0); check(rd, 8'h00);
    rdr(2'h1); check(rd, `OSCSEL_TRIM_RESET);
    rdr(2'h2); check(rd, 8'h00);
    wr(2'h1, 8'h3C); wr(2'h3, 8'hFF);
    rdr(2'h1); check(rd, 8'h3C);
    check(trim_factor, 8'h3C);
    en <= 1'b0;
    wr(2'h1, 8'h55);
    en <= 1'b1;
    rdr(2'h1); check(rd, 8'h3C);
    rdr(2'h3); check(rd, 8'h00);
    for (int s = 0; s < 4; s++) begin
      for (int e = 0; e < 2; e++) begin
        src <= s[1:0];
        wr(2'h2, {7'h0, e[0]});
        repeat (2) @(posedge clk_sys);
        #1 check({5'h0, owned, pin_oe_n, in_shared},
          {5'h0, s == 1 || (s != 3 && e == 0), s == 1 || (s != 3 && e == 0), s == 0});
        // (line above)
        if (s != 1 && s != 3 && e == 1) check({7'h0, pin_o}, {7'h0, full});
      end
      wait_m <= 1'b1; brk <= 1'b1;
      win(128);
      check(near(n_full, n_src), 8'h01);
      check(near(n_full, n_half), 8'h01);
      check({7'h0, n_full > 3}, 8'h01);
    end
    stop_m <= 1'b1;
    win(64); check(n_full[7:0], 8'h00);
    stop_m <= 1'b0; osc_en <= 1'b0;
    win(64); check(n_full[7:0], 8'h00);
    osc_en <= 1'b1; src <= 2'h1;
    for (int b = 0; b < 3; b++) begin
      blk <= 3'h1 << b;
      wr(2'h0, 8'h02); repeat (40) @(posedge clk_sys);
      rdr(2'h0); check(rd & 8'h01, 8'h00);
      wr(2'h0, 8'h00);
    end
    blk <= 3'h0;
    wr(2'h0, 8'h02);
    for (int i = 0; i < 30 && rd[0] !== 1'b1; i++) rdr(2'h0);
    check(rd, 8'h03);
    check({6'h0, int_en, ext_en}, 8'h01);
    eng_exp <= 1'b1;
    win(128);
    check(near(n_full, n_src), 8'h01);
    check({7'h0, n_full > 3}, 8'h01);
    wr(2'h0, 8'h00); run_ext <= 1'b0; src <= 2'h0;
    repeat (30) @(posedge clk_sys);
    rdr(2'h0); check(rd, 8'h01);
    do_reset();
    rdr(2'h0); check(rd, 8'h00);
    #1 check({7'h0, int_en}, 8'h01);
    rdr(2'h1); check(rd, `OSCSEL_TRIM_RESET);
    test_done();
  end
endmodule // testbench
